// File: hdl/bspm_pkg.sv
// Package for the bus-shared port multiplexer: register map, reset
// values, field positions, register selector and pin use encodings.
// Assumes a 32-bit APB register bus and 8-bit ports.
package bspm_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [31:0] BSPM_IDX_P0_DIR   = 32'hfffff001;
	localparam logic [31:0] BSPM_IDX_P1_DATA  = 32'hfffff002;
	localparam logic [31:0] BSPM_IDX_P0_DATA  = 32'hfffff003;
	localparam logic [31:0] BSPM_IDX_P1_FUNC  = 32'hfffff006;
	localparam logic [31:0] BSPM_IDX_P1_DIR   = 32'hfffff007;
	localparam logic [31:0] BSPM_IDX_P2_DATA  = 32'hfffff011;
	localparam logic [31:0] BSPM_IDX_P2_FUNC  = 32'hfffff016;
	localparam logic [31:0] BSPM_IDX_P2_DIR   = 32'hfffff017;
	localparam logic [31:0] BSPM_IDX_STATUS   = 32'hfffff3f0;

	// Index bits compared against paddr[11:2]
	localparam int          BSPM_IDX_W        = 10;

	// ---------------------------------------------------------------
	// Reset values and field positions
	// ---------------------------------------------------------------
	localparam logic [7:0]  BSPM_LATCH_RST    = 8'h00;
	localparam logic [7:0]  BSPM_DIR_RST      = 8'h00;
	localparam logic [7:0]  BSPM_FUNC_RST     = 8'h00;
	localparam int          BSPM_STAT_MUX_BIT = 0;
	localparam int          BSPM_STAT_VLD_BIT = 1;
	localparam int          BSPM_STAT_EXT_BIT = 2;

	// ---------------------------------------------------------------
	// Timing: synchroniser depth before the strap is trusted
	// ---------------------------------------------------------------
	localparam logic [1:0]  BSPM_STRAP_SETTLE = 2'h2;

	// ---------------------------------------------------------------
	// Register selector and pin use ({function, direction})
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		BSPM_REG_NONE    = 4'h0,
		BSPM_REG_P0_DIR  = 4'h1,
		BSPM_REG_P0_DATA = 4'h2,
		BSPM_REG_P1_DATA = 4'h3,
		BSPM_REG_P1_FUNC = 4'h4,
		BSPM_REG_P1_DIR  = 4'h5,
		BSPM_REG_P2_DATA = 4'h6,
		BSPM_REG_P2_FUNC = 4'h7,
		BSPM_REG_P2_DIR  = 4'h8,
		BSPM_REG_STATUS  = 4'h9
	} bspm_reg_t;

	typedef enum logic [1:0] {
		BSPM_USE_IN   = 2'b00,
		BSPM_USE_OUT  = 2'b01,
		BSPM_USE_BUS  = 2'b10,
		BSPM_USE_ADDR = 2'b11
	} bspm_use_t;

	// Address decode, shared by read and write paths
	function automatic bspm_reg_t bspm_decode(input logic [31:0] a);
		logic [BSPM_IDX_W-1:0] i;
		i = a[BSPM_IDX_W+1:2];
		bspm_decode = BSPM_REG_NONE;
		if (a[1:0] == 2'h0 && a[31:BSPM_IDX_W+2] == '0)
		begin
			if (i == BSPM_IDX_P0_DIR[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_P0_DIR;
			if (i == BSPM_IDX_P0_DATA[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_P0_DATA;
			if (i == BSPM_IDX_P1_DATA[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_P1_DATA;
			if (i == BSPM_IDX_P1_FUNC[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_P1_FUNC;
			if (i == BSPM_IDX_P1_DIR[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_P1_DIR;
			if (i == BSPM_IDX_P2_DATA[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_P2_DATA;
			if (i == BSPM_IDX_P2_FUNC[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_P2_FUNC;
			if (i == BSPM_IDX_P2_DIR[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_P2_DIR;
			if (i == BSPM_IDX_STATUS[BSPM_IDX_W-1:0])
				bspm_decode = BSPM_REG_STATUS;
		end
	endfunction

endpackage

// File: hdl/bspm_reg_if.sv
// Register access carrier between the APB slave and the port logic.
// Assumes both ends run on pclk.
`timescale 1ns/100ps
interface bspm_reg_if
	import bspm_pkg::*;
	();
	logic      wr_stb;
	bspm_reg_t sel;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport bus  (output wr_stb, output sel, output wdata, input rdata);
	modport regs (input wr_stb, input sel, input wdata, output rdata);
endinterface

// File: hdl/bspm_sync.sv
// Two-flip-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs are levels that stay stable for several cycles.
`timescale 1ns/100ps
module bspm_sync
	import bspm_pkg::*;
	#(
	parameter int W = 25
	)
	(
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Levels
	input  wire logic [W-1:0] async_in,
	output      logic [W-1:0] sync_out
	);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} bspm_sync_t;

	bspm_sync_t s;
	bspm_sync_t next_s;

	// Refuse a width the synchroniser cannot hold
	if (W < 1)
	begin
		$error("bspm_sync: width must be at least 1");
	end

	// First stage feeds only the second
	always_comb
	begin
		next_s.meta   = async_in;
		next_s.stable = s.meta;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign sync_out = s.stable;
endmodule

// File: hdl/bspm_apb_slave.sv
// APB slave front end: decodes the address, issues write strobes and
// captures read data. Assumes the register side answers combinationally.
`timescale 1ns/100ps
module bspm_apb_slave
	import bspm_pkg::*;
	(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB
	input  wire logic [31:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// Register side
	bspm_reg_if.bus          rif
	);

	typedef struct packed {
		logic [31:0] rdata;
		logic        err;
	} bspm_apb_t;

	bspm_apb_t s;
	bspm_apb_t next_s;
	logic      setup;

	// Decode held through both phases
	assign rif.sel    = bspm_decode(paddr);
	assign rif.wdata  = pwdata[7:0];
	assign rif.wr_stb = psel & penable & pwrite & pstrb[0]
		& (rif.sel != BSPM_REG_NONE);
	assign setup      = psel & ~penable;

	// Capture answer in the setup phase
	always_comb
	begin
		next_s = s;
		if (setup)
		begin
			next_s.rdata = pwrite ? 32'h0000_0000
				: {24'h00_0000, rif.rdata};
			next_s.err   = (rif.sel == BSPM_REG_NONE);
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign pready  = 1'b1;
	assign prdata  = s.rdata;
	assign pslverr = s.err & psel & penable;
endmodule

// File: hdl/bspm_port_mux.sv
// Three 8-bit ports whose pins share the external memory bus.
// Assumes an on-chip bus controller on pclk drives ext_* and an
// APB master on pclk; pins and the strap are asynchronous.
//
// Behaviour
// [R1] Port 0 direction: 0 in, 1 out; reset in
// [R2] Port 0 carries bus data during accesses
// [R3] Port 1 function/direction pair picks pin use
// [R4] Separate mode: port 1 bus use is D15-D8
// [R5] Multiplexed: AD15-AD8; 11 gives A15-A8
// [R6] Reset clears port 1 latch, direction, function
// [R7] Software sets port 1 before bus accesses
// [R8] Strap high at reset picks multiplexed mode
// [R9] Reset clears port 2 latch, direction, function
// [R10] Software sets port 2 before bus accesses
// [R11] Separate mode: port 2 may carry A23-A16
// [R12] Multiplexed: port 2 carries A7-A0 or A23-A16
// [R13] Port 2 pair: in, out, A7-A0, A23-A16
// [R14] Strap low separate D7-D0, high AD7-AD0
// [R15] Data write loads latch; read pin or latch
// [R16] Direction and function registers read as zero
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module bspm_port_mux
	import bspm_pkg::*;
	(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB
	input  wire logic [31:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// Strap
	input  wire logic        bus_mode_strap,
	// External bus controller
	input  wire logic        ext_access,
	input  wire logic        ext_ad_oe,
	input  wire logic [15:0] ext_ad_out,
	input  wire logic [23:0] ext_addr,
	output      logic [15:0] ext_rdata,
	output      logic        bus_mode_mux,
	output      logic        bus_mode_valid,
	// Port 0 pins
	input  wire logic [7:0]  p0_in,
	output      logic [7:0]  p0_out,
	output      logic [7:0]  p0_oe,
	// Port 1 pins
	input  wire logic [7:0]  p1_in,
	output      logic [7:0]  p1_out,
	output      logic [7:0]  p1_oe,
	// Port 2 pins
	input  wire logic [7:0]  p2_in,
	output      logic [7:0]  p2_out,
	output      logic [7:0]  p2_oe
	);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  p0_latch;
		logic [7:0]  p0_dir;
		logic [7:0]  p1_latch;
		logic [7:0]  p1_dir;
		logic [7:0]  p1_func;
		logic [7:0]  p2_latch;
		logic [7:0]  p2_dir;
		logic [7:0]  p2_func;
		logic [1:0]  settle;
		logic        mode_valid;
		logic        mode_mux;
		logic [7:0]  p0_out;
		logic [7:0]  p0_oe;
		logic [7:0]  p1_out;
		logic [7:0]  p1_oe;
		logic [7:0]  p2_out;
		logic [7:0]  p2_oe;
		logic [15:0] ext_rdata;
	} bspm_state_t;

	bspm_state_t s;
	bspm_state_t next_s;

	bspm_reg_if  rif ();

	logic [24:0] pins_sync;
	logic [7:0]  p0_pin;
	logic [7:0]  p1_pin;
	logic [7:0]  p2_pin;
	logic        strap_sync;
	logic [7:0]  rd_val;

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------

	// Pin drive {oe, out} from its use code
	function automatic logic [1:0] pin_drive(
		input bspm_use_t u,
		input logic      latch,
		input logic      bus_oe,
		input logic      bus_bit,
		input logic      hi_bit
		);
		unique case (u)
			BSPM_USE_IN:   pin_drive = {1'b0, latch};
			BSPM_USE_OUT:  pin_drive = {1'b1, latch};
			BSPM_USE_BUS:  pin_drive = {bus_oe, bus_bit};
			BSPM_USE_ADDR: pin_drive = {1'b1, hi_bit};
		endcase
	endfunction

	// Read value: latch where the pin is an output port, else the pin
	function automatic logic [7:0] port_read(
		input logic [7:0] latch,
		input logic [7:0] out_mask,
		input logic [7:0] pin
		);
		port_read = (latch & out_mask) | (pin & ~out_mask);
	endfunction

	// ---------------------------------------------------------------
	// Instances
	// ---------------------------------------------------------------

	// Pins and strap cross into pclk
	bspm_sync #(
		.W        (25)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({bus_mode_strap, p2_in, p1_in, p0_in}),
		.sync_out (pins_sync)
	);

	// APB front end
	bspm_apb_slave u_apb (
		.pclk     (pclk),
		.presetn  (presetn),
		.paddr    (paddr),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.pwdata   (pwdata),
		.pstrb    (pstrb),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.rif      (rif.bus)
	);

	assign p0_pin     = pins_sync[7:0];
	assign p1_pin     = pins_sync[15:8];
	assign p2_pin     = pins_sync[23:16];
	assign strap_sync = pins_sync[24];

	// ---------------------------------------------------------------
	// Register read
	// ---------------------------------------------------------------

	// Read mux; write-only registers return zero
	always_comb
	begin
		rd_val = 8'h00; // R16
		unique case (rif.sel)
			BSPM_REG_P0_DATA:
				rd_val = port_read(s.p0_latch, s.p0_dir, p0_pin); // R15
			BSPM_REG_P1_DATA:
				rd_val = port_read(s.p1_latch, s.p1_dir & ~s.p1_func,
					p1_pin); // R15
			BSPM_REG_P2_DATA:
				rd_val = port_read(s.p2_latch, s.p2_dir & ~s.p2_func,
					p2_pin); // R15
			BSPM_REG_STATUS:
			begin
				rd_val[BSPM_STAT_MUX_BIT] = s.mode_mux;
				rd_val[BSPM_STAT_VLD_BIT] = s.mode_valid;
				rd_val[BSPM_STAT_EXT_BIT] = ext_access;
			end
			default:
				rd_val = 8'h00; // R16
		endcase
	end

	assign rif.rdata = rd_val;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		next_s = s;

		// Register writes
		if (rif.wr_stb)
		begin
			unique case (rif.sel)
				BSPM_REG_P0_DIR:  next_s.p0_dir   = rif.wdata; // R1
				BSPM_REG_P0_DATA: next_s.p0_latch = rif.wdata; // R15
				BSPM_REG_P1_DATA: next_s.p1_latch = rif.wdata; // R15
				BSPM_REG_P1_FUNC: next_s.p1_func  = rif.wdata; // R3
				BSPM_REG_P1_DIR:  next_s.p1_dir   = rif.wdata; // R3
				BSPM_REG_P2_DATA: next_s.p2_latch = rif.wdata; // R15
				BSPM_REG_P2_FUNC: next_s.p2_func  = rif.wdata; // R13
				BSPM_REG_P2_DIR:  next_s.p2_dir   = rif.wdata; // R13
				default:          next_s.settle   = s.settle;
			endcase
		end

		// Strap caught once the synchroniser has settled
		if (!s.mode_valid)
		begin
			if (s.settle == BSPM_STRAP_SETTLE)
			begin
				next_s.mode_valid = 1'b1;
				next_s.mode_mux   = strap_sync; // R8 R14
			end
			else
				next_s.settle = s.settle + 2'h1;
		end

		// Port 0: bus data during accesses, direction bits untouched
		for (int i = 0; i < 8; i++)
		begin
			if (ext_access)
			begin
				next_s.p0_oe[i]  = ext_ad_oe; // R2 R14
				next_s.p0_out[i] = ext_ad_out[i]; // R2
			end
			else
			begin
				next_s.p0_oe[i]  = s.p0_dir[i]; // R1
				next_s.p0_out[i] = s.p0_latch[i];
			end
		end

		// Port 1: 10 is data or AD byte, 11 is A15-A8
		for (int i = 0; i < 8; i++)
		begin
			{next_s.p1_oe[i], next_s.p1_out[i]} = pin_drive(
				bspm_use_t'({s.p1_func[i], s.p1_dir[i]}),
				s.p1_latch[i],
				ext_access & ext_ad_oe,
				ext_ad_out[8+i],
				ext_addr[8+i]); // R3 R4 R5
		end

		// Port 2: 10 is A7-A0, 11 is A23-A16, in either mode
		for (int i = 0; i < 8; i++)
		begin
			{next_s.p2_oe[i], next_s.p2_out[i]} = pin_drive(
				bspm_use_t'({s.p2_func[i], s.p2_dir[i]}),
				s.p2_latch[i],
				1'b1,
				ext_addr[i],
				ext_addr[16+i]); // R11 R12 R13
		end

		// Bus read data from the data pins
		next_s.ext_rdata = {p1_pin, p0_pin};
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------

	// Every latch, direction and function bit clears on reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s          <= '0;
			s.p0_dir   <= BSPM_DIR_RST; // R1
			s.p0_latch <= BSPM_LATCH_RST;
			s.p1_latch <= BSPM_LATCH_RST; // R6
			s.p1_dir   <= BSPM_DIR_RST; // R6
			s.p1_func  <= BSPM_FUNC_RST; // R6
			s.p2_latch <= BSPM_LATCH_RST; // R9
			s.p2_dir   <= BSPM_DIR_RST; // R9
			s.p2_func  <= BSPM_FUNC_RST; // R9
		end
		else
			s <= next_s;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign p0_out         = s.p0_out;
	assign p0_oe          = s.p0_oe;
	assign p1_out         = s.p1_out;
	assign p1_oe          = s.p1_oe;
	assign p2_out         = s.p2_out;
	assign p2_oe          = s.p2_oe;
	assign ext_rdata      = s.ext_rdata;
	assign bus_mode_mux   = s.mode_mux;
	assign bus_mode_valid = s.mode_valid;
endmodule

// File: sim/bspm_pin_load.sv
// Pin load model for one 8-bit port of the multiplexer.
// Assumes the bench gives the level of the undriven external source.
`timescale 1ns/100ps
module bspm_pin_load
	(
	// Port side
	input  wire logic [7:0] out,
	input  wire logic [7:0] oe,
	// External source
	input  wire logic [7:0] src,
	output      logic [7:0] pin
	);
	// Driven pins follow the port, others the source
	assign pin = (out & oe) | (src & ~oe);
endmodule

// File: sim/bspm_port_mux_chk.sv
// Checker bound to the port multiplexer top module.
// Assumes one pclk domain and byte addresses 4, 18h, 1ch for settings.
`timescale 1ns/100ps
module bspm_port_mux_chk
	(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic [31:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	// Mode and bus controller
	input wire logic        bus_mode_strap,
	input wire logic        bus_mode_mux,
	input wire logic        bus_mode_valid,
	input wire logic        ext_access,
	input wire logic        ext_ad_oe,
	input wire logic [15:0] ext_ad_out,
	input wire logic [23:0] ext_addr,
	// Pins
	input wire logic [7:0]  p0_out,
	input wire logic [7:0]  p0_oe,
	input wire logic [7:0]  p1_out,
	input wire logic [7:0]  p1_oe,
	input wire logic [7:0]  p2_oe
	);
	// -------------------------------------------------------------
	// Shadow of the port 0 and port 1 write-only settings
	// -------------------------------------------------------------
	logic [7:0] dir0, dir1, fn1, oe1_x, am1, hi_a, lo_d;
	logic       wr;
	// Helper terms: write strobe, and values for one-cycle-late comparisons
	assign wr = psel && penable && pwrite && pstrb[0];
	assign oe1_x = dir1 | (fn1 & {8{ext_access && ext_ad_oe}});
	assign am1 = dir1 & fn1;
	assign hi_a = ext_addr[15:8];
	assign lo_d = ext_ad_out[7:0];
	// Track accepted writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dir0 <= 8'h00;
			dir1 <= 8'h00;
			fn1 <= 8'h00;
		end
		else if (wr)
		begin
			if (paddr == 32'h00000004)
				dir0 <= pwdata[7:0];
			if (paddr == 32'h0000001c)
				dir1 <= pwdata[7:0];
			if (paddr == 32'h00000018)
				fn1 <= pwdata[7:0];
		end
	end
	// -------------------------------------------------------------
	// Properties
	// -------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cap;
		$rose(bus_mode_valid);
	endsequence
	AST_RST_IN: assert property (
		$rose(presetn) |-> (p0_oe | p1_oe | p2_oe) == 8'h00)
		else $error("pins not inputs after reset");
	AST_MODE_CAP: assert property (
		s_cap |-> bus_mode_mux == bus_mode_strap)
		else $error("bus mode differs from strap");
	AST_MODE_HOLD: assert property (
		bus_mode_valid |=> $stable(bus_mode_mux) && bus_mode_valid)
		else $error("bus mode changed after capture");
	AST_P0_BUS: assert property (
		ext_access |=> p0_oe == {8{$past(ext_ad_oe)}}
			&& p0_out == $past(lo_d))
		else $error("port 0 not carrying bus data");
	AST_P0_DIR: assert property (
		!ext_access |=> p0_oe == $past(dir0))
		else $error("port 0 enable differs from direction");
	AST_P1_OE: assert property (
		1'b1 |=> p1_oe == $past(oe1_x))
		else $error("port 1 enable wrong for pin use");
	AST_P1_ADDR: assert property (
		1'b1 |=> (p1_out & $past(am1)) == ($past(hi_a) & $past(am1)))
		else $error("port 1 address byte wrong");
	AST_WO_READ: assert property (
		psel && penable && !pwrite
			&& paddr inside {32'h4, 32'h18, 32'h1c} |-> prdata == 32'h0)
		else $error("setting register read not zero");
endmodule
bind bspm_port_mux bspm_port_mux_chk i_chk (.pclk, .presetn, .paddr,
	.psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .bus_mode_strap,
	.bus_mode_mux, .bus_mode_valid, .ext_access, .ext_ad_oe, .ext_ad_out,
	.ext_addr, .p0_out, .p0_oe, .p1_out, .p1_oe, .p2_oe);

// File: sim/test_bus_shared_port_mux.sv
// Self-checking bench for the bus-shared port multiplexer.
// Assumes zero-wait APB and one-cycle registered pin outputs.
`timescale 1ns/100ps
module test_bus_shared_port_mux;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        bus_mode_strap, bus_mode_mux, bus_mode_valid, er;
	logic        ext_access, ext_ad_oe;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [15:0] ext_ad_out, ext_rdata;
	logic [23:0] ext_addr;
	logic [7:0]  src, p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe;
	logic [7:0]  p2_in, p2_out, p2_oe;
	int          n_fail, num_checks;
	typedef struct packed
	{
		logic [31:0] wa;
		logic [7:0]  wd;
		logic [31:0] ra;
		logic [7:0]  ex;
	} bspm_row_t;
	// Write, then read back; undriven pins show 3ch
	bspm_row_t rows [8] = '{'{32'h8, 8'ha5, 32'h8, 8'h3c},
		'{32'h1c, 8'h0f, 32'h8, 8'h35}, '{32'h1c, 8'h0f, 32'h1c, 8'h00},
		'{32'h44, 8'hc3, 32'h44, 8'h3c}, '{32'h5c, 8'hff, 32'h44, 8'hc3},
		'{32'hc, 8'h81, 32'hc, 8'h3c}, '{32'h4, 8'hf0, 32'hc, 8'h8c},
		'{32'h18, 8'hf0, 32'h18, 8'h00}};
	// -------------------------------------------------------------
	// Design, pin loads, clock
	// -------------------------------------------------------------
	bspm_port_mux i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_mode_strap(bus_mode_strap),
		.ext_access(ext_access), .ext_ad_oe(ext_ad_oe),
		.ext_ad_out(ext_ad_out), .ext_addr(ext_addr),
		.ext_rdata(ext_rdata),
		.bus_mode_mux(bus_mode_mux), .bus_mode_valid(bus_mode_valid),
		.p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p1_in(p1_in),
		.p1_out(p1_out), .p1_oe(p1_oe), .p2_in(p2_in), .p2_out(p2_out),
		.p2_oe(p2_oe));
	bspm_pin_load i_ld0 (.out(p0_out), .oe(p0_oe), .src(src), .pin(p0_in));
	bspm_pin_load i_ld1 (.out(p1_out), .oe(p1_oe), .src(src), .pin(p1_in));
	bspm_pin_load i_ld2 (.out(p2_out), .oe(p2_oe), .src(src), .pin(p2_in));
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// -------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic close_out;
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One APB transfer; result in rd and er
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst(input logic s);
		presetn <= 1'b0;
		bus_mode_strap <= s;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		do @(posedge pclk); while (bus_mode_valid !== 1'b1);
		chk({31'h0, bus_mode_mux}, {31'h0, s});
		chk({8'h0, p0_oe, p1_oe, p2_oe}, 32'h0);
	endtask
	// -------------------------------------------------------------
	// Sequence and watchdog
	// -------------------------------------------------------------
	initial
	begin
		{presetn, psel, penable, pwrite, ext_access, ext_ad_oe} = '0;
		{paddr, pwdata, ext_ad_out, ext_addr} = '0;
		pstrb = 4'hf;
		src = 8'h3c;
		rst(1'b1);
		apb(1'b0, 32'hfc0, 32'h0);
		chk(rd, 32'h3);
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].wa, {24'h0, rows[i].wd});
			repeat (4) @(posedge pclk);
			apb(1'b0, rows[i].ra, 32'h0);
			chk(rd, {24'h0, rows[i].ex});
		end
		// Address use on ports 1 and 2, set up before bus traffic
		apb(1'b1, 32'h18, 32'hff);
		apb(1'b1, 32'h1c, 32'hff);
		apb(1'b1, 32'h58, 32'hff);
		ext_addr <= 24'habcdef;
		repeat (3) @(posedge pclk);
		chk({8'h0, p1_oe, p1_out, p2_out}, 32'hffcdab);
		apb(1'b1, 32'h5c, 32'h0);
		repeat (2) @(posedge pclk);
		chk({p2_oe, p2_out}, 32'hffef);
		// External access with data driven, then released
		apb(1'b1, 32'h1c, 32'h0);
		ext_access <= 1'b1;
		ext_ad_oe <= 1'b1;
		ext_ad_out <= 16'h1234;
		repeat (2) @(posedge pclk);
		chk({p0_oe, p0_out, p1_oe, p1_out}, 32'hff34ff12);
		apb(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h0);
		chk({16'h0, ext_rdata}, 32'h1234);
		ext_ad_oe <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({p0_oe, p1_oe}, 32'h0);
		ext_access <= 1'b0;
		// Refused accesses: unmapped and misaligned
		apb(1'b0, 32'h100, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 32'h9, 32'h55);
		chk({31'h0, er}, 32'h1);
		// Write with the low byte lane off leaves the latch alone
		pstrb <= 4'he;
		apb(1'b1, 32'hc, 32'h99);
		chk({31'h0, er}, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, 32'hc, 32'h0);
		chk(rd, 32'h8c);
		// Second reset in separate mode; latches cleared
		rst(1'b0);
		apb(1'b0, 32'hfc0, 32'h0);
		chk(rd, 32'h2);
		apb(1'b1, 32'h1c, 32'hff);
		apb(1'b1, 32'h5c, 32'hff);
		repeat (4) @(posedge pclk);
		apb(1'b0, 32'h8, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 32'h44, 32'h0);
		chk(rd, 32'h0);
		close_out();
	end
	initial
	begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		close_out();
	end
endmodule
